/* src/assp_pkg.sv */
// Constants and carrier types of the serial port (UART / 3-wire).
// Assumes a byte-wide CPU port that decodes the 16-bit addresses below.
package assp_pkg;
  // ---------------------------------------------------------------
  // Register addresses and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_ASYNC = 16'hff70;
  localparam logic [15:0] ADDR_STAT  = 16'hff71;
  localparam logic [15:0] ADDR_SYNC  = 16'hff72;
  localparam logic [15:0] ADDR_BAUD  = 16'hff73;
  localparam logic [15:0] ADDR_DATA  = 16'hff74;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  // Error status bit positions
  localparam int ERR_PAR = 2;
  localparam int ERR_FRM = 1;
  localparam int ERR_OVR = 0;
  // ---------------------------------------------------------------
  // Timing counts
  // ---------------------------------------------------------------
  localparam logic [2:0] TICK_LAST   = 3'h7;  // 8 ticks per bit
  localparam logic [2:0] TICK_HALF   = 3'h3;  // half a bit
  localparam logic [3:0] BAUD_MAXSEL = 4'h6;
  localparam logic [3:0] BAUD_OFS    = 4'h3;
  localparam logic [3:0] BAUD_SLOW   = 4'h9;
  localparam logic [2:0] BIT_LAST8   = 3'h7;
  localparam logic [2:0] BIT_LAST7   = 3'h6;
  localparam logic [3:0] SYNC_LAST   = 4'h7;  // 8 bits a transfer
  // ---------------------------------------------------------------
  // Register layouts
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PAR_NONE = 2'b00, PAR_ZERO = 2'b01, PAR_ODD = 2'b10, PAR_EVEN = 2'b11
  } assp_par_t;
  typedef struct packed {
    logic      txEnable;
    logic      rxEnable;
    assp_par_t paritySel;
    logic      charLength;
    logic      stopLength;
    logic [1:0] rsvd;
  } assp_async_t;
  typedef struct packed {
    logic       syncEnable;
    logic [2:0] rsvd;
    logic       dataPhase;
    logic       bitOrder;
    logic       clockSource;
    logic       clockPolarity;
  } assp_sync_t;
endpackage : assp_pkg

/* src/assp_serial.sv */
// Serial port: UART transmitter/receiver and 3-wire synchronous shifter.
// Assumes pins come from outside the clk domain; CPU port is synchronous.
`timescale 1ns/10ps

// ---------------------------------------------------------------
// Small FIFO in the transmit data path
// ---------------------------------------------------------------
module assp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;

  // Full when indexes meet but wrap bits differ
  assign outValid = (wrPtr_q != rdPtr_q);
  assign inReady  = !((wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]) &&
                      (wrPtr_q[AW] != rdPtr_q[AW]));
  assign outData  = mem_q[rdPtr_q[AW-1:0]];

  // Storage needs no reset, pointers define content
  always_ff @(posedge clk) begin
    if (inValid && inReady) begin
      mem_q[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  // Pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (inValid && inReady) wrPtr_q <= wrPtr_q + 1'b1;
      if (outValid && outReady) rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
endmodule : assp_fifo

// Overview of operation
// R1: No parity: none sent, none checked
// R2: Tx enable bit 7; data write starts frame
// R3: Shift out, tx interrupt when register empty
// R4: Rx enable bit 6 samples receive line
// R5: Half-bit recheck confirms start bit
// R6: Frame ends after one stop bit
// R7: Frame end copies to buffer, rx interrupt
// R8: Rx disable aborts; buffer, status kept
// R9: Enabling rx with line low starts receive
// R10: Parity, framing, overrun flags at frame end
// R11: Buffer read or next frame clears status
// R12: Software reads status before buffer
// R13: Software delays or sets bit order first
// R14: Software reloads ones after tx abort
// R15: Late rx disable outcome depends on position
// R16: Software never rewrites async mode mid-transmit
// R17: Sync enable bit 7 gates 3-wire mode
// R18: Data phase picks falling or rising drive
// R19: Bit order: 0 MSB first, 1 LSB
// R20: Clock source: pin or baud generator
// R21: Clock polarity sets idle level
// R22: Software zeroes async mode in 3-wire mode
// R23: 3-wire transfer is eight bits, then interrupt
// R24: Reset idles tx line high, receiver idle
module assp_serial (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] cpuAddr,
  input  wire logic        cpuWr,
  input  wire logic        cpuRd,
  input  wire logic [7:0]  cpuWdata,
  output logic [7:0]       cpuRdata,
  input  wire logic        rxLine,
  output logic             txLine,
  input  wire logic        sdIn,
  output logic             sdOut,
  input  wire logic        sckIn,
  output logic             sckOut,
  output logic             sckOe,
  output logic             txDoneIrq,
  output logic             rxDoneIrq,
  output logic             syncDoneIrq
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_START = 3'b001, ST_DATA = 3'b011,
    ST_PAR = 3'b010, ST_STOP = 3'b110
  } assp_state_t;

  assp_pkg::assp_async_t asyncQ;
  assp_pkg::assp_sync_t  syncQ;
  logic [7:0]  baudSel_q, rxBuf_q, rxSh_q, txSh_q, sySh_q, cpuRdata_q;
  logic [2:0]  errStat_q, pinMeta_q, pinSync_q, rxSub_q, txSub_q;
  logic [2:0]  rxIdx_q, txIdx_q;
  logic [9:0]  preCnt_q;
  logic [3:0]  syCnt_q;
  assp_state_t rxSt_q, txSt_q;
  logic rxFull_q, rxPar_q, txPar_q, txStop2_q, txLine_q, sdOut_q;
  logic sckOut_q, sckOe_q, sckPrev_q, syBusy_q;
  logic txDoneIrq_q, rxDoneIrq_q, syncDoneIrq_q;

  // ---------------------------------------------------------------
  // Pin synchronisers: {rx, sd, sck}
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta_q <= 3'h7;
      pinSync_q <= 3'h7;
    end else begin
      pinMeta_q <= {rxLine, sdIn, sckIn};
      pinSync_q <= pinMeta_q;
    end
  end
  logic rxIn, sdInS, sckInS;
  assign {rxIn, sdInS, sckInS} = pinSync_q;

  // ---------------------------------------------------------------
  // CPU registers
  // ---------------------------------------------------------------
  logic wrData, rdBuf, fifoReady, fifoValid, fifoPop;
  logic [7:0] fifoData;
  assign wrData = cpuWr && (cpuAddr == assp_pkg::ADDR_DATA);
  assign rdBuf  = cpuRd && (cpuAddr == assp_pkg::ADDR_DATA);

  // Mode registers; reserved async bits forced low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      asyncQ    <= assp_pkg::REG_RESET;
      syncQ     <= assp_pkg::REG_RESET;
      baudSel_q <= assp_pkg::REG_RESET;
    end else if (cpuWr) begin
      if (cpuAddr == assp_pkg::ADDR_ASYNC) asyncQ <= {cpuWdata[7:2], 2'b00};
      if (cpuAddr == assp_pkg::ADDR_SYNC) syncQ <= {cpuWdata[7], 3'h0,
                                                    cpuWdata[3:0]};
      if (cpuAddr == assp_pkg::ADDR_BAUD) baudSel_q <= {cpuWdata[7:4], 4'h0};
    end
  end

  // Read data is registered, so it appears one cycle after cpuRd
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuRdata_q <= 8'h00;
    end else if (cpuRd) begin
      case (cpuAddr)
        assp_pkg::ADDR_ASYNC: cpuRdata_q <= asyncQ;
        assp_pkg::ADDR_STAT:  cpuRdata_q <= {5'h00, errStat_q};
        assp_pkg::ADDR_SYNC:  cpuRdata_q <= syncQ;
        assp_pkg::ADDR_BAUD:  cpuRdata_q <= baudSel_q;
        assp_pkg::ADDR_DATA:  cpuRdata_q <= rxBuf_q;
        default:              cpuRdata_q <= 8'h00;
      endcase
    end
  end

  // Writes only land while a transmitter is enabled and room exists
  assp_fifo #(.WIDTH(8), .DEPTH(4)) u_txFifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (wrData && (asyncQ.txEnable || syncQ.syncEnable)), // R2
    .inReady  (fifoReady),
    .inData   (cpuWdata),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );

  // ---------------------------------------------------------------
  // Baud generator: tick every 2^(n+3) clocks, 8 ticks per bit
  // ---------------------------------------------------------------
  logic [3:0] preShift;
  logic [9:0] preMask;
  logic       tick;
  // Timer and external sources are not modelled; they run slowest
  assign preShift = (baudSel_q[7:4] <= assp_pkg::BAUD_MAXSEL) ?
                    baudSel_q[7:4] + assp_pkg::BAUD_OFS : assp_pkg::BAUD_SLOW;
  assign preMask  = (10'h001 << preShift) - 10'h001;
  assign tick     = ((preCnt_q & preMask) == preMask);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) preCnt_q <= 10'h000;
    else        preCnt_q <= preCnt_q + 10'h001;
  end

  // ---------------------------------------------------------------
  // UART transmitter
  // ---------------------------------------------------------------
  logic asyncPop, syncPop, txBit;
  logic [2:0] txLast;
  logic [7:0] txMasked;
  assign txLast   = asyncQ.charLength ? assp_pkg::BIT_LAST8
                                      : assp_pkg::BIT_LAST7;
  assign txMasked = asyncQ.charLength ? fifoData : {1'b0, fifoData[6:0]};
  assign asyncPop = !syncQ.syncEnable && asyncQ.txEnable &&
                    (txSt_q == ST_IDLE) && fifoValid;
  assign syncPop  = syncQ.syncEnable && !syBusy_q && fifoValid;
  assign fifoPop  = asyncPop || syncPop;
  assign txBit    = tick && (txSub_q == assp_pkg::TICK_LAST);

  // Frame sequencer; disabling tx aborts to a high line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txSt_q <= ST_IDLE;
      txLine_q <= 1'b1; // R24
      txSh_q <= 8'h00;
      txSub_q <= 3'h0;
      txIdx_q <= 3'h0;
      txPar_q <= 1'b0;
      txStop2_q <= 1'b0;
      txDoneIrq_q <= 1'b0;
    end else begin
      txDoneIrq_q <= 1'b0;
      if (tick) txSub_q <= txSub_q + 3'h1;
      if (!asyncQ.txEnable) begin
        txSt_q <= ST_IDLE;
        txLine_q <= 1'b1;
      end else if (asyncPop) begin
        txSt_q <= ST_START; // R2
        txLine_q <= 1'b0;
        txSh_q <= txMasked;
        txSub_q <= 3'h0;
        txIdx_q <= 3'h0;
        case (asyncQ.paritySel)
          assp_pkg::PAR_ODD:  txPar_q <= ~^txMasked;
          assp_pkg::PAR_EVEN: txPar_q <= ^txMasked;
          default:            txPar_q <= 1'b0;
        endcase
      end else if (txBit) begin
        case (txSt_q)
          ST_START: begin
            txSt_q <= ST_DATA;
            txLine_q <= txSh_q[0];
            txSh_q <= txSh_q >> 1;
          end
          ST_DATA: begin
            if (txIdx_q != txLast) begin
              txIdx_q <= txIdx_q + 3'h1;
              txLine_q <= txSh_q[0];
              txSh_q <= txSh_q >> 1;
            end else if (asyncQ.paritySel != assp_pkg::PAR_NONE) begin
              txSt_q <= ST_PAR;
              txLine_q <= txPar_q;
            end else begin
              txSt_q <= ST_STOP; // R1
              txLine_q <= 1'b1;
              txStop2_q <= asyncQ.stopLength;
            end
          end
          ST_PAR: begin
            txSt_q <= ST_STOP;
            txLine_q <= 1'b1;
            txStop2_q <= asyncQ.stopLength;
          end
          ST_STOP: begin
            if (txStop2_q) begin
              txStop2_q <= 1'b0;
            end else begin
              txSt_q <= ST_IDLE;
              txDoneIrq_q <= 1'b1; // R3
            end
          end
          default: txSt_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // UART receiver
  // ---------------------------------------------------------------
  logic rxSample, rxFinish, rxParErr;
  logic [2:0] rxLast;
  assign rxLast   = asyncQ.charLength ? assp_pkg::BIT_LAST8
                                      : assp_pkg::BIT_LAST7;
  assign rxSample = tick && (rxSub_q == assp_pkg::TICK_LAST);
  assign rxFinish = asyncQ.rxEnable && rxSample && (rxSt_q == ST_STOP);
  // Zero parity and no parity never report an error
  always_comb begin
    case (asyncQ.paritySel)
      assp_pkg::PAR_ODD:  rxParErr = ~^{rxSh_q, rxPar_q};
      assp_pkg::PAR_EVEN: rxParErr = ^{rxSh_q, rxPar_q};
      default:            rxParErr = 1'b0; // R1
    endcase
  end

  // Start detect, then a sample at each bit centre
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxSt_q <= ST_IDLE; // R24
      rxSub_q <= 3'h0;
      rxIdx_q <= 3'h0;
      rxSh_q <= 8'h00;
      rxPar_q <= 1'b0;
    end else if (!asyncQ.rxEnable) begin
      rxSt_q <= ST_IDLE; // R8
    end else begin
      if (tick) rxSub_q <= rxSub_q + 3'h1;
      case (rxSt_q)
        ST_IDLE: begin
          if (!rxIn) begin
            rxSt_q <= ST_START; // R9
            rxSub_q <= 3'h0;
          end
        end
        ST_START: begin
          if (tick && rxSub_q == assp_pkg::TICK_HALF) begin
            rxSt_q <= rxIn ? ST_IDLE : ST_DATA; // R5
            rxSub_q <= 3'h0;
            rxIdx_q <= 3'h0;
            rxSh_q <= 8'h00;
          end
        end
        ST_DATA: begin
          if (rxSample) begin
            rxSh_q[rxIdx_q] <= rxIn; // R4
            rxIdx_q <= rxIdx_q + 3'h1;
            if (rxIdx_q == rxLast) begin
              rxSt_q <= (asyncQ.paritySel == assp_pkg::PAR_NONE) ?
                        ST_STOP : ST_PAR;
            end
          end
        end
        ST_PAR: begin
          if (rxSample) begin
            rxPar_q <= rxIn;
            rxSt_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (rxSample) rxSt_q <= ST_IDLE; // R6
        end
        default: rxSt_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // 3-wire shifter
  // ---------------------------------------------------------------
  logic master, rise, fall, drvEdge, smpEdge, syncFinish;
  logic [7:0] syShNext;
  assign master  = syncQ.clockSource; // R20
  assign rise    = master ? (syBusy_q && tick && !sckOut_q)
                          : (sckInS && !sckPrev_q);
  assign fall    = master ? (syBusy_q && tick && sckOut_q)
                          : (!sckInS && sckPrev_q);
  assign drvEdge = syncQ.dataPhase ? rise : fall; // R18
  assign smpEdge = syncQ.dataPhase ? fall : rise;
  assign syShNext = syncQ.bitOrder ? {sdInS, sySh_q[7:1]}
                                   : {sySh_q[6:0], sdInS}; // R19
  assign syncFinish = syBusy_q && smpEdge && (syCnt_q == assp_pkg::SYNC_LAST);

  // Shared shift register: out bit at one end, in bit at the other
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syBusy_q <= 1'b0;
      syCnt_q <= 4'h0;
      sySh_q <= 8'h00;
      sdOut_q <= 1'b1;
      sckPrev_q <= 1'b1;
      sckOut_q <= 1'b1;
      sckOe_q <= 1'b0;
      syncDoneIrq_q <= 1'b0;
    end else begin
      sckPrev_q <= sckInS;
      syncDoneIrq_q <= 1'b0;
      sckOe_q <= syncQ.syncEnable && master;
      if (!syncQ.syncEnable) begin
        syBusy_q <= 1'b0; // R17
        sckOut_q <= !syncQ.clockPolarity;
      end else if (syncPop) begin
        syBusy_q <= 1'b1;
        syCnt_q <= 4'h0;
        sySh_q <= fifoData;
        sdOut_q <= syncQ.bitOrder ? fifoData[0] : fifoData[7];
      end else if (syBusy_q) begin
        if (master && tick) sckOut_q <= !sckOut_q;
        if (drvEdge) sdOut_q <= syncQ.bitOrder ? sySh_q[0] : sySh_q[7];
        if (smpEdge) begin
          sySh_q <= syShNext;
          syCnt_q <= syCnt_q + 4'h1;
        end
        if (syncFinish) begin
          syBusy_q <= 1'b0; // R23
          sckOut_q <= !syncQ.clockPolarity; // R21
          syncDoneIrq_q <= 1'b1;
        end
      end else begin
        sckOut_q <= !syncQ.clockPolarity; // R21
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive buffer and error status; a new result beats a read
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxBuf_q <= 8'h00;
      errStat_q <= 3'h0;
      rxFull_q <= 1'b0;
      rxDoneIrq_q <= 1'b0;
    end else begin
      rxDoneIrq_q <= 1'b0;
      if (rdBuf) begin
        errStat_q <= 3'h0; // R11
        rxFull_q <= 1'b0;
      end
      if (rxFinish) begin
        rxBuf_q <= rxSh_q; // R7
        rxDoneIrq_q <= 1'b1; // R15
        rxFull_q <= 1'b1;
        errStat_q[assp_pkg::ERR_PAR] <= rxParErr; // R10
        errStat_q[assp_pkg::ERR_FRM] <= !rxIn;
        errStat_q[assp_pkg::ERR_OVR] <= rxFull_q;
      end else if (syncFinish) begin
        rxBuf_q <= syShNext;
        rxFull_q <= 1'b1;
      end
    end
  end

  assign cpuRdata    = cpuRdata_q;
  assign txLine      = txLine_q;
  assign sdOut       = sdOut_q;
  assign sckOut      = sckOut_q;
  assign sckOe       = sckOe_q;
  assign txDoneIrq   = txDoneIrq_q;
  assign rxDoneIrq   = rxDoneIrq_q;
  assign syncDoneIrq = syncDoneIrq_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rxEnd;
    rxFinish;
  endsequence
  sequence s_sent;
    (txSt_q == ST_START) && !txLine_q;
  endsequence
  property p_noParity;
    (rxFinish && asyncQ.paritySel == assp_pkg::PAR_NONE)
      |=> !errStat_q[assp_pkg::ERR_PAR];
  endproperty
  a_noParity: assert property (p_noParity) // R1
    else $error("parity error flagged with parity off");
  property p_txStart;
    asyncPop |=> s_sent;
  endproperty
  a_txStart: assert property (p_txStart) // R2
    else $error("start bit not driven after load");
  property p_txIrq;
    txDoneIrq_q |-> $past(txSt_q == ST_STOP) ##1 !txDoneIrq_q;
  endproperty
  a_txIrq: assert property (p_txIrq) // R3
    else $error("tx interrupt not a single pulse after stop");
  property p_rxAbort;
    (!asyncQ.rxEnable && !rxFinish) |=> (rxSt_q == ST_IDLE) && !rxDoneIrq_q;
  endproperty
  a_rxAbort: assert property (p_rxAbort) // R8
    else $error("receiver ran while disabled");
  property p_rxCopy;
    s_rxEnd |=> (rxBuf_q == $past(rxSh_q)) && rxDoneIrq_q;
  endproperty
  a_rxCopy: assert property (p_rxCopy) // R7
    else $error("frame end did not load buffer");
  property p_readClr;
    (rdBuf && !rxFinish) |=> (errStat_q == 3'h0);
  endproperty
  a_readClr: assert property (p_readClr) // R11
    else $error("buffer read left error flags");
  property p_overrun;
    (rxFinish && rxFull_q) |=> errStat_q[assp_pkg::ERR_OVR];
  endproperty
  a_overrun: assert property (p_overrun) // R10
    else $error("overrun not flagged");
  property p_syncDone;
    syncFinish |-> (syCnt_q == 4'h7) ##1 (syncDoneIrq_q && !syBusy_q);
  endproperty
  a_syncDone: assert property (p_syncDone) // R23
    else $error("sync transfer not eight bits");
  property p_idleHigh;
    (txSt_q == ST_IDLE) |-> txLine_q;
  endproperty
  a_idleHigh: assert property (p_idleHigh) // R24
    else $error("tx line low while idle");
endmodule : assp_serial

/* testbench/assp_peer.sv */
// Remote UART peer: drives the receive line, decodes the transmit line.
// Assumes baud select 0 (64 clocks a bit) and 8-bit frames, no parity.
`timescale 1ns/10ps
module assp_peer (
  input  wire logic clk,
  input  wire logic txLine,
  output logic      rxLine
);
  // ---------------------------------------------------------------
  // Sender and decoder
  // ---------------------------------------------------------------
  logic [7:0] gotQ[$];      // Bytes seen on the transmit line
  int         stopBad = 0;  // Frames whose stop sample was low

  initial rxLine = 1'b1;  // Idle mark, line pulled up

  // Last bit cut short so no false start can follow it
  task automatic sendBits(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxLine = f[i];
      repeat (i == n - 1 ? 48 : 64) @(posedge clk);
      #1;
    end
    rxLine = 1'b1;
  endtask : sendBits

  // Start bit may be short: realign on the first rising edge
  always begin : rx_decode
    int         c;
    int         d;
    int         t;
    logic [8:0] b;
    @(negedge txLine);
    c = 0;
    while (txLine !== 1'b1) begin
      @(posedge clk);
      c++;
    end
    d = c;
    for (int i = 0; i < 9; i++) begin
      t = (d - 2) % 64 + 1 + 32 + 64 * i;
      while (c < t) begin
        @(posedge clk);
        c++;
      end
      b[i] = (t < d) ? 1'b0 : txLine;
    end
    if (b[8] !== 1'b1) stopBad++;
    gotQ.push_back(b[7:0]);
  end
endmodule : assp_peer

/* testbench/async_sync_serial_port_bench.sv */
// Self-checking bench: UART both ways, error flags, 3-wire master.
// Assumes assp_peer on the UART pins and the baud select left at 0.
`timescale 1ns/10ps
module async_sync_serial_port_bench;
  // ---------------------------------------------------------------
  // Pins, model state and helpers
  // ---------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] cpuAddr = 16'h0000;
  logic        cpuWr = 1'b0;
  logic        cpuRd = 1'b0;
  logic [7:0]  cpuWdata = 8'h00;
  logic [7:0]  cpuRdata, pat, cap;
  logic        rxLine, txLine, sdOut, sckIn, sckOut, sckOe;
  logic        sdIn = 1'b1;
  logic        ph = 1'b0;  // Data phase the 3-wire peer follows
  logic        txDoneIrq, rxDoneIrq, syncDoneIrq;
  logic [31:0] seed = 32'h6155893e;
  logic [7:0]  expQ[$];  // Bytes the transmitter still owes
  int          fail_count = 0, compares = 0, cyc = 0;
  int          k = 0, nR = 0, txN = 0, rxN = 0, syN = 0;

  always #5 clk = ~clk;
  assign sckIn = sckOe ? sckOut : 1'b1;  // Clock pin pulled up

  assp_serial i_assp_serial (.clk(clk), .rst_n(rst_n), .cpuAddr(cpuAddr),
    .cpuWr(cpuWr), .cpuRd(cpuRd), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata),
    .rxLine(rxLine), .txLine(txLine), .sdIn(sdIn), .sdOut(sdOut),
    .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe), .txDoneIrq(txDoneIrq),
    .rxDoneIrq(rxDoneIrq), .syncDoneIrq(syncDoneIrq));
  assp_peer i_assp_peer (.clk(clk), .txLine(txLine), .rxLine(rxLine));

  // Interrupt counts and watchdog
  always @(posedge clk) begin
    txN += (txDoneIrq === 1'b1);
    rxN += (rxDoneIrq === 1'b1);
    syN += (syncDoneIrq === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  // 3-wire peer: capture on the sample edge, next bit on the drive edge
  always @(sckOut) begin
    if (sckOut ^ ph) begin
      cap = {cap[6:0], sdOut};
      nR++;
    end else begin
      #1 sdIn = pat[7 - (k & 7)];
      k++;
    end
  end

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
  endfunction : rev
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Strobes dropped for a cycle so no signal changes twice at once
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cpuAddr = a;
    cpuWdata = d;
    cpuWr = 1'b1;
    tick(1);
    cpuWr = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    cpuAddr = a;
    cpuRd = 1'b1;
    tick(1);
    cpuRd = 1'b0;
    chk(cpuRdata, exp);
    tick(1);
  endtask : rd
  task automatic conclude();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin : main
    logic [7:0] d, p;
    logic [7:0] es[3];
    int         n;
    es = '{8'h00, 8'h04, 8'h02};
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    tick(1);
    rd(16'hff70, 8'h00);
    rd(16'hff71, 8'h00);
    rd(16'hff72, 8'h00);
    rd(16'hff7f, 8'h00);
    chk({6'h0, sckOe, txLine}, 8'h01);
    wr(16'hff70, 8'hc8);
    rd(16'hff70, 8'hc8);
    // Four bytes queued behind the transmitter
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      expQ.push_back(d);
      wr(16'hff74, d);
    end
    wait (txN == 4);
    tick(2);
    chk(8'(i_assp_peer.gotQ.size()), 8'h04);
    for (int i = 0; i < 4; i++) begin
      chk(i_assp_peer.gotQ.pop_front(), expQ.pop_front());
    end
    chk(8'(i_assp_peer.stopBad), 8'h00);
    // Clean frames; third left unread so the fourth overruns
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      i_assp_peer.sendBits({3'b111, d, 1'b0}, 10);
      tick(12);
      if (i != 2) begin
        rd(16'hff71, i == 3 ? 8'h01 : 8'h00);
        rd(16'hff74, d);
        rd(16'hff71, 8'h00);
      end
    end
    chk(8'(rxN), 8'h04);
    // Zero, odd, even parity; last frame also lacks its stop bit
    for (int i = 0; i < 3; i++) begin
      d = rnd();
      wr(16'hff70, 8'hd8 + 8'(i * 16));
      i_assp_peer.sendBits({1'b1, i != 2, ^d, d, 1'b0}, 11);
      tick(12);
      rd(16'hff71, es[i]);
      rd(16'hff74, d);
    end
    // 7-bit frame: the buffer's top bit reads 0
    d = rnd();
    wr(16'hff70, 8'hc0);
    i_assp_peer.sendBits({4'hf, d[6:0], 1'b0}, 9);
    tick(12);
    d[7] = 1'b0;
    rd(16'hff71, 8'h00);
    rd(16'hff74, d);
    // Receive enable cleared in mid-frame
    wr(16'hff70, 8'hc8);
    fork
      i_assp_peer.sendBits({3'b111, ~d, 1'b0}, 10);
      begin
        tick(300);
        wr(16'hff70, 8'h88);
      end
    join
    tick(12);
    chk(8'(rxN), 8'h08);
    rd(16'hff71, 8'h00);
    rd(16'hff74, d);
    wr(16'hff70, 8'h00);
    // 3-wire master: MSB first, LSB first, then data phase 1 idling low
    for (int m = 0; m < 3; m++) begin
      d = rnd();
      p = rnd();
      ph = (m == 2);
      pat = (m == 1) ? rev(p) : p;
      wr(16'hff72, m == 2 ? 8'h8b : (m == 1 ? 8'h86 : 8'h82));
      tick(2);
      chk({6'h0, sckOe, sckOut}, ph ? 8'h02 : 8'h03);
      k = 0;
      nR = 0;
      sdIn = pat[7];
      n = syN;
      wr(16'hff74, d);
      wait (syN == n + 1);
      tick(2);
      chk(cap, (m == 1) ? rev(d) : d);
      chk(8'(nR), 8'h08);
      rd(16'hff74, p);
    end
    wr(16'hff72, 8'h81);
    tick(3);
    chk({6'h0, sckOe, sckOut}, 8'h00);
    chk(8'(txN), 8'h04);
    conclude();
  end
endmodule : async_sync_serial_port_bench
